// ---- dv/test_two_wire_serial_controller.sv ----
// Self-checking bench for the two-wire controller.
// Assumes a peer slave at 2Ah and a bench-driven master for slave modes.
`timescale 1ns/1ps
`default_nettype none
module test_two_wire_serial_controller;
logic clk;
logic rst_n;
logic [7:0] reg_addr;
logic reg_wr;
logic reg_rd;
logic [7:0] reg_wdata;
logic rx_ready;
logic tb_scl;
logic tb_sda;
logic slow;
wire [7:0] reg_rdata;
wire [7:0] rx_byte;
wire [7:0] got;
wire scl_out, scl_oe, sda_out, sda_oe, rx_valid, p_scl, p_sda, nack;
wire scl = (scl_oe | scl_out) & p_scl & tb_scl;
wire sda = (sda_oe | sda_out) & p_sda & tb_sda;
int miscompares;
int n_checks;
int seed;
int i;
int j;
logic [7:0] v;
logic [7:0] d;
logic [7:0] rs;
logic r;
twsc_ctrl twsc_ctrl_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .scl_in(scl),
   .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
   .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte));
twsc_peer twsc_peer_inst (.scl(scl), .sda(sda), .scl_rel(p_scl), .sda_rel(p_sda),
   .slow(slow), .got(got), .nack(nack));
initial
begin
   clk = 1'b0;
   forever #10 clk = ~clk;
end
////////////////////////////////////////
task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
   n_checks++;
   if (s !== e)
   begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
   end
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] w);
   @(posedge clk);
   #2;
   reg_addr = a;
   reg_wdata = w;
   reg_wr = 1'b1;
   @(posedge clk);
   #2;
   reg_wr = 1'b0;
endtask
task automatic rd(input logic [7:0] a, output logic [7:0] q);
   @(posedge clk);
   #2;
   reg_addr = a;
   reg_rd = 1'b1;
   @(posedge clk);
   #2;
   reg_rd = 1'b0;
   q = reg_rdata;
endtask
task automatic rc(input logic [7:0] a, input logic [7:0] e);
   logic [7:0] q;
   rd(a, q);
   chk($sformatf("reg %h", a), q, e);
endtask
task automatic wt(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
   logic [7:0] q;
   int k;
   q = ~e;
   for (k = 0; k < 4000 && (q & m) !== e; k++)
      rd(a, q);
   chk("wait", q & m, e);
endtask
// Bench master bit at the 160 ns link period, honouring stretch
task automatic mbit(input logic b, output logic q);
   tb_sda = b;
   #40;
   tb_scl = 1'b1;
   wait (scl === 1'b1);
   #40;
   q = sda;
   #40;
   tb_scl = 1'b0;
   #40;
endtask
task automatic mbyte(input logic [7:0] b, output logic q);
   int k;
   for (k = 7; k >= 0; k--)
      mbit(b[k], q);
   mbit(1'b1, q);
endtask
task automatic sstart;
   tb_sda = 1'b0;
   #80;
   tb_scl = 1'b0;
   #40;
endtask
task automatic sstop;
   tb_sda = 1'b0;
   #40;
   tb_scl = 1'b1;
   wait (scl === 1'b1);
   #80;
   tb_sda = 1'b1;
   #80;
endtask
function automatic logic [7:0] exp_rst(input int k);
   case (k)
      0: return 8'h00;
      1: return 8'hf8;
      2: return 8'hff;
      3: return 8'hfe;
      default: return 8'h00;
   endcase
endfunction
task automatic finish_test;
   $display("checks %0d mismatches %0d", n_checks, miscompares);
   if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
   else
      $display("TESTS FAILED");
   $finish;
endtask
////////////////////////////////////////
initial
begin
   seed = 16;
   miscompares = 0;
   n_checks = 0;
   rst_n = 1'b0;
   reg_addr = 8'h00;
   reg_wr = 1'b0;
   reg_rd = 1'b0;
   reg_wdata = 8'h00;
   rx_ready = 1'b0;
   tb_scl = 1'b1;
   tb_sda = 1'b1;
   slow = 1'b0;
   repeat (16) @(posedge clk);
   #2;
   rst_n = 1'b1;
   for (i = 0; i < 5; i++)
      rc(8'h93 + i[7:0], exp_rst(i));
   v = 8'($random(seed)) | 8'h80;
   wr(8'h96, v);
   rc(8'h96, v);
   wr(8'h95, 8'h5a);
   rc(8'h95, 8'hff);
   wr(8'h93, 8'h08);
   rc(8'h93, 8'h00);
   $display("test registers done");
   rs = ($random(seed) & 1) ? 8'h82 : 8'h00;
   wr(8'h93, 8'h60 | rs);
   wt(8'h93, 8'h08, 8'h08);
   rc(8'h94, 8'h08);
   chk("scl held", {7'h0, scl}, 8'h00);
   wr(8'h95, {7'h2a, 1'b0});
   wr(8'h93, 8'h40 | rs);
   wt(8'h93, 8'h08, 8'h08);
   rc(8'h94, 8'h18);
   d = 8'($random(seed));
   wr(8'h95, d);
   wr(8'h93, 8'h44 | rs);
   wt(8'h93, 8'h08, 8'h08);
   rc(8'h94, 8'h18);
   chk("peer byte", got, d);
   rc(8'h93, 8'h4c | rs);
   wr(8'h93, 8'h50 | rs);
   wt(8'h94, 8'hff, 8'hf8);
   $display("test master write done");
   slow = 1'($random(seed));
   wr(8'h93, 8'h64 | rs);
   wt(8'h93, 8'h08, 8'h08);
   wr(8'h95, {7'h2a, 1'b1});
   wr(8'h93, 8'h44 | rs);
   wt(8'h93, 8'h08, 8'h08);
   // Stream is stalled while four bytes arrive
   for (i = 0; i < 4; i++)
   begin
      wr(8'h93, ((i < 3) ? 8'h44 : 8'h40) | rs);
      wt(8'h93, 8'h08, 8'h08);
      rc(8'h94, (i < 3) ? 8'h40 : 8'h50);
      rc(8'h95, 8'h3c + i[7:0]);
      chk("peer nack", {7'h0, nack}, (i < 3) ? 8'h00 : 8'h01);
   end
   wr(8'h93, 8'h50 | rs);
   wt(8'h94, 8'hff, 8'hf8);
   for (i = 0; i < 4; i++)
   begin
      for (j = 0; j < 9 && rx_valid !== 1'b1; j++)
         @(posedge clk);
      chk("rx byte", rx_byte, 8'h3c + i[7:0]);
      rx_ready = 1'b1;
      @(posedge clk);
      #2;
      rx_ready = 1'b0;
      @(posedge clk);
      #2;
   end
   repeat (4) @(posedge clk);
   chk("rx empty", {7'h0, rx_valid}, 8'h00);
   $display("test master read done");
   wr(8'h93, 8'h40);
   sstart;
   mbyte({v[7:1], 1'b0}, r);
   chk("slave nack", {7'h0, r}, 8'h01);
   rc(8'h94, 8'hf8);
   sstop;
   wr(8'h93, 8'h44);
   sstart;
   mbyte({v[7:1], 1'b0}, r);
   chk("slave ack", {7'h0, r}, 8'h00);
   wt(8'h93, 8'h08, 8'h08);
   rc(8'h94, 8'h60);
   d = 8'($random(seed));
   wr(8'h93, 8'h44);
   mbyte(d, r);
   chk("data ack", {7'h0, r}, 8'h00);
   wt(8'h93, 8'h08, 8'h08);
   rc(8'h94, 8'h80);
   rc(8'h95, d);
   wr(8'h93, 8'h40);
   mbyte(~d, r);
   chk("data nack", {7'h0, r}, 8'h01);
   repeat (20) @(posedge clk);
   wr(8'h93, 8'h40);
   sstop;
   $display("test slave receive done");
   wr(8'h93, 8'h44);
   sstart;
   mbyte({v[7:1], 1'b1}, r);
   wt(8'h93, 8'h08, 8'h08);
   rc(8'h94, 8'ha8);
   wr(8'h95, d);
   // Ack-assert clear marks this byte as the last one
   wr(8'h93, 8'h40);
   for (j = 7; j >= 0; j--)
   begin
      mbit(1'b1, r);
      rs[j] = r;
   end
   chk("slave tx", rs, d);
   mbit(1'b0, r);
   mbit(1'b1, r);
   chk("detached", {7'h0, r}, 8'h01);
   rc(8'h94, 8'hb8);
   sstop;
   $display("test slave transmit done");
   finish_test;
end
// Whole run needs about 17000 cycles at most; over five times that means a hang
initial
begin
   repeat (90000) @(posedge clk);
   miscompares++;
   finish_test;
end
endmodule
`default_nettype wire

// ---- dv/twsc_peer.sv ----
// Behavioural slave on the two-wire bus.
// Assumes wired-and levels with pull-ups built by the bench.
`timescale 1ns/1ps
`default_nettype none
module twsc_peer #(
   parameter [6:0] ADDR = 7'h2a,
   parameter [7:0] TX0 = 8'h3c
)
(
   // Bus levels and releases
   input wire logic scl,
   input wire logic sda,
   output logic scl_rel,
   output logic sda_rel,
   // Control and observation
   input wire logic slow,
   output logic [7:0] got,
   output logic nack
);
logic [3:0] n;
logic [7:0] sh;
logic [7:0] tx;
logic act;
logic adr;
logic sel;
logic rd;
initial
begin
   scl_rel = 1'b1;
   sda_rel = 1'b1;
   act = 1'b0;
   sel = 1'b0;
   tx = TX0;
   nack = 1'b0;
   got = 8'h00;
end
always @(negedge sda)
   if (scl === 1'b1)
   begin
      act = 1'b1;
      adr = 1'b1;
      sel = 1'b0;
      // The start's own clock fall wraps this to zero
      n = 4'hf;
   end
always @(posedge sda)
   if (scl === 1'b1)
   begin
      act = 1'b0;
      sel = 1'b0;
   end
always @(posedge scl)
   if (act && n < 4'h8)
      sh = {sh[6:0], sda};
   else if (act && sel && rd)
      nack = sda;
always @(negedge scl)
   if (act)
   begin
      sda_rel = 1'b1;
      if (n == 4'h8)
      begin
         n = 4'h0;
         if (sel && rd && !nack)
            sda_rel = tx[7];
      end
      else
      begin
         n = n + 4'h1;
         if (n == 4'h8 && adr)
         begin
            sel = sh[7:1] == ADDR;
            rd = sh[0];
            adr = 1'b0;
            nack = 1'b0;
            sda_rel = !sel;
         end
         else if (n == 4'h8 && sel)
         begin
            got = sh;
            tx = tx + {7'h0, rd};
            sda_rel = rd;
         end
         else if (sel && rd && n < 4'h8)
            sda_rel = tx[3'd7 - n[2:0]];
         // Slow answer: stretch the clock in the ack slot
         if (slow && sel && n == 4'h8)
         begin
            scl_rel = 1'b0;
            #2000;
            scl_rel = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/twsc_properties.sv ----
// Port checker for the two-wire controller, bound to twsc_ctrl.
// Assumes one clock domain and reads answered one cycle late.
`timescale 1ns/1ps
`default_nettype none
module twsc_props (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Register port
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   // Bus pins
   input wire scl_in,
   input wire scl_out,
   input wire scl_oe,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   // Byte stream
   input wire rx_valid,
   input wire rx_ready,
   input wire [7:0] rx_byte
);
default clocking @(posedge clk);
endclocking
default disable iff (!rst_n);
reg [7:0] ctl;
reg [7:0] adr;
reg ctl_wr;
reg en_ever;
reg [3:0] off;
wire wc = reg_wr && reg_addr == 8'h93;
wire rc = reg_rd && !reg_wr && reg_addr == 8'h93;
wire rs = reg_rd && !reg_wr && reg_addr == 8'h94;
always @(posedge clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      ctl <= 8'h00;
      adr <= 8'hfe;
      ctl_wr <= 1'b0;
      en_ever <= 1'b0;
      off <= 4'h0;
   end
   else
   begin
      if (wc)
      begin
         ctl <= reg_wdata;
         ctl_wr <= 1'b1;
         en_ever <= en_ever | reg_wdata[6];
      end
      if (reg_wr && reg_addr == 8'h96)
         adr <= reg_wdata;
      // Saturates so a long idle stays flagged
      off <= ctl[6] ? 4'h0 : (off == 4'hf ? off : off + 4'h1);
   end
end
////////////////////////////////////////
property p_ctrl_rst; rc && !ctl_wr |=> reg_rdata == 8'h00; endproperty
a_ctrl_rst: assert property (p_ctrl_rst) else $error("control not zero");
property p_ctrl_back; rc |=> (reg_rdata & 8'hc7) == (ctl & 8'hc7); endproperty
a_ctrl_back: assert property (p_ctrl_back) else $error("rate bits lost");
property p_stat_low; rs |=> reg_rdata[2:0] == 3'h0; endproperty
a_stat_low: assert property (p_stat_low) else $error("status low bits set");
property p_stat_rst; rs && !en_ever |=> reg_rdata == 8'hf8; endproperty
a_stat_rst: assert property (p_stat_rst) else $error("status not idle");
property p_data_rst; reg_rd && reg_addr == 8'h95 && !en_ever |=> reg_rdata == 8'hff; endproperty
a_data_rst: assert property (p_data_rst) else $error("data not all ones");
property p_addr_back; reg_rd && !reg_wr && reg_addr == 8'h96 |=> reg_rdata == adr; endproperty
a_addr_back: assert property (p_addr_back) else $error("own address wrong");
property p_off_idle; off == 4'hf |-> scl_oe && sda_oe; endproperty
a_off_idle: assert property (p_off_idle) else $error("disabled but driving");
property p_start;
   wc && reg_wdata[6:5] == 2'b11 && !reg_wdata[4] && scl_oe && sda_oe && scl_in && sda_in
   |-> ##[1:12] !sda_oe && scl_oe;
endproperty
a_start: assert property (p_start) else $error("start not issued");
property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_byte); endproperty
a_rx_hold: assert property (p_rx_hold) else $error("stream byte dropped");
c_start: cover property (wc && reg_wdata[5]);
c_drain: cover property (rx_valid && rx_ready);
c_slave: cover property (rs ##1 reg_rdata == 8'h60);
endmodule
bind twsc_ctrl twsc_props twsc_props_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .rx_byte(rx_byte));
`default_nettype wire

// ---- hdl/twsc_ctrl.v ----
// Two-wire serial controller: registers, master/slave byte engine, bus pins.
// Assumes scl/sda inputs come from open-drain pads; oe low means drive low.
`timescale 1ns/1ps
`default_nettype none
`include "twsc_regs.vh"

module twsc_ctrl
(
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Register port
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // Bus pins
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   // Received byte stream
   output reg rx_valid,
   input wire rx_ready,
   output reg [7:0] rx_byte
);
   localparam PH_IDLE = 3'd0;
   localparam PH_START = 3'd1;
   localparam PH_BIT = 3'd2;
   localparam PH_ACK = 3'd3;
   localparam PH_WAIT = 3'd4;
   localparam PH_STOP = 3'd5;

   reg [7:0] serial_control;
   reg [4:0] bus_state_code;
   reg [7:0] serial_shift_data;
   reg [7:0] own_slave_address;
   reg [2:0] phase;
   reg [2:0] bit_cnt;
   reg [9:0] div_cnt;
   reg [1:0] quarter;
   reg master;
   reg rx_mode;
   reg addr_phase;
   reg rx_push;
   reg scl_m1, scl_s, scl_d;
   reg sda_m1, sda_s, sda_d;
   reg [9:0] div_limit;
   wire ctl_enable;
   wire ctl_flag;
   wire ctl_ack;
   wire [2:0] rate;
   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;
   wire tick;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire addr_hit;
   wire gc_hit;

   assign ctl_enable = serial_control[`TWSC_CTRL_ENABLE];
   assign ctl_flag = serial_control[`TWSC_CTRL_FLAG];
   assign ctl_ack = serial_control[`TWSC_CTRL_ACK];
   assign rate = {serial_control[`TWSC_CTRL_RATE_HI], serial_control[1:0]};
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign bus_start = scl_s && scl_d && sda_d && !sda_s;
   assign bus_stop = scl_s && scl_d && !sda_d && sda_s;
   assign tick = (div_cnt == 10'd0);
   assign addr_hit = ctl_ack && (serial_shift_data[7:1] == own_slave_address[7:1]);
   assign gc_hit = ctl_ack && own_slave_address[0] && (serial_shift_data == 8'h00);

   ////////////////////////////////////////////////////////////
   // Pin synchronisers
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_m1 <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m1 <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_m1 <= scl_in;
         scl_s <= scl_m1;
         scl_d <= scl_s;
         sda_m1 <= sda_in;
         sda_s <= sda_m1;
         sda_d <= sda_s;
      end
   end

   ////////////////////////////////////////////////////////////
   // Rate table: quarter-bit divisor; arbitrary spread of rates
   always @*
   begin
      case (rate)
         3'd0: div_limit = 10'd63;
         3'd1: div_limit = 10'd79;
         3'd2: div_limit = 10'd99;
         3'd3: div_limit = 10'd127;
         3'd4: div_limit = 10'd255;
         3'd5: div_limit = 10'd511;
         3'd6: div_limit = 10'd31;
         default: div_limit = 10'd1023;
      endcase
   end

   ////////////////////////////////////////////////////////////
   // Received byte FIFO; a full FIFO drops the received byte
   twsc_fifo #(.WIDTH(8), .DEPTH(`TWSC_FIFO_DEPTH), .AW(2)) u_fifo
   (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(rx_push),
      .in_ready(fifo_in_ready),
      .in_data(serial_shift_data),
      .out_valid(fifo_out_valid),
      .out_ready(rx_ready && rx_valid),
      .out_data(fifo_out_data)
   );

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_valid <= 1'b0;
         rx_byte <= 8'h00;
      end
      else
      begin
         rx_valid <= fifo_out_valid && !(rx_ready && rx_valid);
         rx_byte <= fifo_out_data;
      end
   end

   ////////////////////////////////////////////////////////////
   // Registers and byte engine
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_control <= `TWSC_CTRL_RESET;
         bus_state_code <= `TWSC_ST_IDLE;
         serial_shift_data <= `TWSC_DATA_RESET;
         own_slave_address <= `TWSC_ADDR_RESET;
         reg_rdata <= 8'h00;
         phase <= PH_IDLE;
         bit_cnt <= 3'd7;
         div_cnt <= 10'd0;
         quarter <= 2'd0;
         master <= 1'b0;
         rx_mode <= 1'b0;
         addr_phase <= 1'b0;
         scl_out <= 1'b0;
         scl_oe <= 1'b1;
         sda_out <= 1'b0;
         sda_oe <= 1'b1;
         rx_push <= 1'b0;
      end
      else
      begin
         rx_push <= 1'b0;
         if (reg_rd)
         begin
            case (reg_addr)
               `TWSC_CTRL_ADDR: reg_rdata <= serial_control;
               `TWSC_STAT_ADDR: reg_rdata <= {bus_state_code, 3'b000};
               `TWSC_DATA_ADDR: reg_rdata <= serial_shift_data;
               `TWSC_ADDR_ADDR: reg_rdata <= own_slave_address;
               default: reg_rdata <= 8'h00;
            endcase
         end
         if (reg_wr && reg_addr == `TWSC_CTRL_ADDR)
            // Flag bit may only be cleared by software, never set
            serial_control <= {reg_wdata[7:4], reg_wdata[3] & ctl_flag, reg_wdata[2:0]};
         if (reg_wr && reg_addr == `TWSC_DATA_ADDR && ctl_flag)
            serial_shift_data <= reg_wdata;
         if (reg_wr && reg_addr == `TWSC_ADDR_ADDR)
            own_slave_address <= reg_wdata;
         div_cnt <= tick ? div_limit : div_cnt - 10'd1;
         // Stretch clock while service is pending
         scl_oe <= !(ctl_flag && phase != PH_IDLE && !scl_s) && (master ? scl_oe : 1'b1);
         if (!ctl_enable)
         begin
            phase <= PH_IDLE;
            master <= 1'b0;
            bus_state_code <= `TWSC_ST_IDLE;
            scl_oe <= 1'b1;
            sda_oe <= 1'b1;
         end
         else if (bus_stop && !master && phase != PH_STOP)
         begin
            phase <= PH_IDLE;
            sda_oe <= 1'b1;
         end
         else if (bus_start && !master && ctl_ack)
         begin
            phase <= PH_BIT;
            addr_phase <= 1'b1;
            rx_mode <= 1'b1;
            bit_cnt <= 3'd7;
         end
         else
         begin
            case (phase)
               PH_IDLE:
               begin
                  if (serial_control[`TWSC_CTRL_START] && !ctl_flag && scl_s && sda_s)
                  begin
                     sda_oe <= 1'b0;
                     master <= 1'b1;
                     phase <= PH_START;
                  end
               end
               PH_START:
               begin
                  if (tick)
                  begin
                     scl_oe <= 1'b0;
                     serial_control[`TWSC_CTRL_START] <= 1'b0;
                     serial_control[`TWSC_CTRL_FLAG] <= 1'b1;
                     bus_state_code <= `TWSC_ST_START;
                     phase <= PH_WAIT;
                     addr_phase <= 1'b1;
                  end
               end
               PH_WAIT:
               begin
                  // Slave lets go of its ack, or shows its first bit, once SCL is low
                  if (!master && !scl_s)
                     sda_oe <= rx_mode | serial_shift_data[7];
                  if (!ctl_flag)
                  begin
                     if (master && serial_control[`TWSC_CTRL_STOP])
                     begin
                        sda_oe <= 1'b0;
                        phase <= PH_STOP;
                        quarter <= 2'd0;
                     end
                     else
                     begin
                        if (addr_phase && master)
                           rx_mode <= serial_shift_data[0];
                        bit_cnt <= 3'd7;
                        quarter <= 2'd0;
                        phase <= PH_BIT;
                     end
                  end
               end
               PH_BIT:
               begin
                  // Second half waits for SCL high, so a stretching slave is honoured
                  if (master && tick && (!quarter[1] || scl_s))
                  begin
                     quarter <= quarter + 2'd1;
                     if (quarter == 2'd0)
                        sda_oe <= (rx_mode && !addr_phase) | serial_shift_data[7];
                     if (quarter == 2'd1)
                        scl_oe <= 1'b1;
                     if (quarter == 2'd2 && scl_s)
                        serial_shift_data <= {serial_shift_data[6:0], sda_s};
                     if (quarter == 2'd3)
                     begin
                        scl_oe <= 1'b0;
                        bit_cnt <= bit_cnt - 3'd1;
                        if (bit_cnt == 3'd0)
                           phase <= PH_ACK;
                     end
                  end
                  else if (!master)
                  begin
                     if (scl_fall && !rx_mode)
                        sda_oe <= serial_shift_data[7];
                     if (scl_rise)
                     begin
                        serial_shift_data <= {serial_shift_data[6:0], sda_s};
                        bit_cnt <= bit_cnt - 3'd1;
                        if (bit_cnt == 3'd0)
                           phase <= PH_ACK;
                     end
                  end
               end
               PH_ACK:
               begin
                  if (master && tick && (!quarter[1] || scl_s))
                  begin
                     quarter <= quarter + 2'd1;
                     if (quarter == 2'd0)
                        sda_oe <= !(rx_mode && !addr_phase && ctl_ack);
                     if (quarter == 2'd1)
                        scl_oe <= 1'b1;
                     if (quarter == 2'd3)
                     begin
                        scl_oe <= 1'b0;
                        serial_control[`TWSC_CTRL_FLAG] <= 1'b1;
                        if (rx_mode && !addr_phase)
                        begin
                           rx_push <= fifo_in_ready;
                           bus_state_code <= ctl_ack ? `TWSC_ST_MR_ACK : `TWSC_ST_MR_NACK;
                        end
                        else
                           bus_state_code <= sda_s ? `TWSC_ST_MT_NACK : `TWSC_ST_MT_ACK;
                        addr_phase <= 1'b0;
                        phase <= PH_WAIT;
                     end
                  end
                  else if (!master)
                  begin
                     if (scl_fall && sda_oe && rx_mode)
                     begin
                        if (addr_phase)
                           sda_oe <= !(addr_hit || gc_hit);
                        else
                           sda_oe <= !ctl_ack;
                     end
                     else if (scl_fall && !rx_mode)
                        sda_oe <= 1'b1;
                     if (scl_rise)
                     begin
                        if (addr_phase && !(addr_hit || gc_hit))
                           phase <= PH_IDLE;
                        else
                        begin
                           serial_control[`TWSC_CTRL_FLAG] <= 1'b1;
                           if (addr_phase)
                           begin
                              rx_mode <= !serial_shift_data[0];
                              bus_state_code <= gc_hit ? `TWSC_ST_SR_GC :
                                 (serial_shift_data[0] ? `TWSC_ST_ST_ADDR : `TWSC_ST_SR_ADDR);
                           end
                           else if (rx_mode)
                           begin
                              rx_push <= fifo_in_ready;
                              bus_state_code <= `TWSC_ST_SR_DATA;
                           end
                           else
                              bus_state_code <= `TWSC_ST_ST_DATA;
                           addr_phase <= 1'b0;
                           phase <= (!rx_mode && !addr_phase && (!ctl_ack || sda_s)) ?
                              PH_IDLE : PH_WAIT;
                        end
                     end
                  end
               end
               PH_STOP:
               begin
                  if (tick)
                  begin
                     quarter <= quarter + 2'd1;
                     if (quarter == 2'd1)
                        scl_oe <= 1'b1;
                     if (quarter == 2'd3)
                     begin
                        sda_oe <= 1'b1;
                        serial_control[`TWSC_CTRL_STOP] <= 1'b0;
                        master <= 1'b0;
                        bus_state_code <= `TWSC_ST_IDLE;
                        phase <= PH_IDLE;
                     end
                  end
               end
               default: phase <= PH_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ---- hdl/twsc_fifo.v ----
// Small valid/ready FIFO holding received bytes for the received byte stream.
// Assumes both sides on clk.
`timescale 1ns/1ps
`default_nettype none
module twsc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW = 2
)
(
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @(posedge clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/twsc_regs.vh ----
// Register map, field positions, reset values, status codes and FIFO depth for the two-wire controller.
// Assumes a byte-wide special-function-register port on the core clock.
`ifndef TWSC_REGS_VH
`define TWSC_REGS_VH

`define TWSC_CTRL_ADDR 8'h93
`define TWSC_STAT_ADDR 8'h94
`define TWSC_DATA_ADDR 8'h95
`define TWSC_ADDR_ADDR 8'h96

`define TWSC_CTRL_RATE_HI 7
`define TWSC_CTRL_ENABLE 6
`define TWSC_CTRL_START 5
`define TWSC_CTRL_STOP 4
`define TWSC_CTRL_FLAG 3
`define TWSC_CTRL_ACK 2

`define TWSC_CTRL_RESET 8'h00
`define TWSC_STAT_RESET 8'hf8
`define TWSC_DATA_RESET 8'hff
`define TWSC_ADDR_RESET 8'hfe

`define TWSC_ST_IDLE 5'h1f
`define TWSC_ST_START 5'h01
`define TWSC_ST_MT_ACK 5'h03
`define TWSC_ST_MT_NACK 5'h04
`define TWSC_ST_MR_ACK 5'h08
`define TWSC_ST_MR_NACK 5'h0a
`define TWSC_ST_MR_DATA 5'h0b
`define TWSC_ST_SR_ADDR 5'h0c
`define TWSC_ST_SR_GC 5'h0e
`define TWSC_ST_SR_DATA 5'h10
`define TWSC_ST_ST_ADDR 5'h15
`define TWSC_ST_ST_DATA 5'h17
`define TWSC_ST_ST_LAST 5'h19
`define TWSC_ST_STOP 5'h14

`define TWSC_FIFO_DEPTH 4

`endif
